// ==== hw/lvsc_top.sv ====
// Low-voltage subclock mode controller: clock control, protected
// regulator level, power-mode derivation and peripheral run gating.
// Assumes software on an Avalon-MM master; every reset source of the
// chip (pin, watchdog, voltage detector, clock monitor) drives RESET_I.
`timescale 1ns/1ps
`default_nettype none
module lvsc_top
  import lvsc_pkg::*;
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESET_I,
  input  wire logic [7:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  input  wire lvsc_busy_t  BUSY_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  output lvsc_clk_t        CLK_CTRL_O,
  output lvsc_mode_t       MODE_O,
  output lvsc_run_t        RUN_O
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]  pcc_reg;
  logic [7:0]  pll_reg;
  logic [7:0]  lvl_reg;
  logic [7:0]  prot_reg;
  logic [7:0]  clksel_reg;
  logic [7:0]  slow_reg;
  logic [31:0] rdata_reg;
  lvsc_mode_t  mode_reg;
  lvsc_mode_t  mode_next;
  lvsc_run_t   run_reg;
  lvsc_run_t   run_next;
  lvsc_clk_t   clk_reg;

  logic        capture;
  logic        wr_stb;
  logic        wr_lane;
  logic [7:0]  wbyte;
  logic        prot_open;
  logic        slow_sel;
  logic        hang;
  logic [7:0]  status;
  logic [7:0]  rd_mux;
  logic [7:0]  pcc_next;

  assign wbyte     = AVS_WRITEDATA_I[7:0];
  assign wr_lane   = wr_stb && AVS_BYTEENABLE_I[0];
  assign prot_open = (prot_reg == PROT_ENABLE);
  assign slow_sel  = (AVS_ADDRESS_I == OFS_SLOWREG);
  // Wait-state access on subclock with main stopped can never complete
  assign hang      = slow_sel && pcc_reg[PCC_SUB_BIT]
                     && pcc_reg[PCC_MCK_BIT];

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  lvsc_avmm_slave u_slave (
    .clk_i         (SYS_CLK_I),
    .rst_i         (RESET_I),
    .read_i        (AVS_READ_I),
    .write_i       (AVS_WRITE_I),
    .slow_i        (slow_sel),
    .hang_i        (hang),
    .waitrequest_o (AVS_WAITREQUEST_O),
    .capture_o     (capture),
    .wr_stb_o      (wr_stb)
  );

  // ----------------------------------------------------------------
  // Processor clock control
  // ----------------------------------------------------------------
  always_comb begin
    pcc_next = wbyte;
    // Regulator must be back at normal level before leaving subclock
    if (lvl_reg != LVL_NORMAL)
      pcc_next[PCC_SUB_BIT] = 1'b1;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I)
      pcc_reg <= PCC_RST;
    else if (wr_lane && AVS_ADDRESS_I == OFS_PCC)
      pcc_reg <= pcc_next;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I)
      pll_reg <= PLL_RST;
    else if (wr_lane && AVS_ADDRESS_I == OFS_PLL)
      pll_reg <= {7'h00, wbyte[PLL_ON_BIT]};
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I)
      clksel_reg <= CLKSEL_RST;
    else if (wr_lane && AVS_ADDRESS_I == OFS_CLKSEL)
      clksel_reg <= {2'h0, wbyte[5:0]};
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I)
      slow_reg <= SLOWREG_RST;
    else if (wr_lane && slow_sel)
      slow_reg <= wbyte;
  end

  // ----------------------------------------------------------------
  // Regulator protection and level
  // ----------------------------------------------------------------
  // Any value but the unlock code relocks
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I)
      prot_reg <= PROT_RST;
    else if (wr_lane && AVS_ADDRESS_I == OFS_REGPROT)
      prot_reg <= (wbyte == PROT_ENABLE) ? PROT_ENABLE : PROT_LOCK;
  end

  // Unlock stays open until relocked, so several level writes may pass
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I)
      lvl_reg <= LVL_RST;
    else if (wr_lane && AVS_ADDRESS_I == OFS_REGLVL && prot_open)
      lvl_reg <= wbyte;
  end

  // ----------------------------------------------------------------
  // Power mode
  // ----------------------------------------------------------------
  always_comb begin
    if (lvl_reg == LVL_LOW)
      mode_next = MODE_LVSUB;
    else if (pcc_reg[PCC_SUB_BIT])
      mode_next = MODE_SUB;
    else
      mode_next = MODE_NORMAL;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I)
      mode_reg <= MODE_NORMAL;
    else
      mode_reg <= mode_next;
  end

  lvsc_gate u_gate (
    .mode_i   (mode_next),
    .clksel_i (clksel_reg),
    .run_o    (run_next)
  );

  // Reset value: everything runs, as in normal mode
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I)
      run_reg <= '1;
    else
      run_reg <= run_next;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      clk_reg <= '0;
    end else begin
      clk_reg.pll_on        <= pll_reg[PLL_ON_BIT];
      clk_reg.main_osc_stop <= pcc_reg[PCC_MCK_BIT];
      clk_reg.subclk_sel    <= pcc_reg[PCC_SUB_BIT];
      clk_reg.sysclk_div    <= pcc_reg[PCC_DIV_LSB +: 3];
      clk_reg.reg_low       <= (lvl_reg == LVL_LOW);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Busy flags only reported; the block cannot stop those units
  always_comb begin
    status               = 8'h00;
    status[STAT_SUB]     = pcc_reg[PCC_SUB_BIT];
    status[STAT_LV]      = (mode_reg == MODE_LVSUB);
    status[STAT_PROT_EN] = prot_open;
    status[STAT_DMA]     = BUSY_I.dma;
    status[STAT_DAC]     = BUSY_I.dac;
    status[STAT_CRC]     = BUSY_I.crc;
  end

  always_comb begin
    if (AVS_ADDRESS_I == OFS_PCC)
      rd_mux = pcc_reg;
    else if (AVS_ADDRESS_I == OFS_PLL)
      rd_mux = pll_reg;
    else if (AVS_ADDRESS_I == OFS_REGLVL)
      rd_mux = lvl_reg;
    else if (AVS_ADDRESS_I == OFS_REGPROT)
      rd_mux = prot_reg;
    else if (AVS_ADDRESS_I == OFS_CLKSEL)
      rd_mux = clksel_reg;
    else if (AVS_ADDRESS_I == OFS_STATUS)
      rd_mux = status;
    else if (slow_sel)
      rd_mux = slow_reg;
    else
      rd_mux = 8'h00;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I)
      rdata_reg <= 32'h0000_0000;
    else if (capture && AVS_READ_I)
      rdata_reg <= {24'h00_0000, rd_mux};
  end

  assign AVS_READDATA_O = rdata_reg;
  assign CLK_CTRL_O     = clk_reg;
  assign MODE_O         = mode_reg;
  assign RUN_O          = run_reg;

endmodule
`default_nettype wire

// ==== hw/lvsc_pkg.sv ====
// Constants, types and helpers for the low-voltage subclock mode controller.
// Assumes a single 250 MHz system clock and a synchronous active-high reset.
package lvsc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PCC     = 8'h00;
  localparam logic [7:0] OFS_PLL     = 8'h04;
  localparam logic [7:0] OFS_REGLVL  = 8'h08;
  localparam logic [7:0] OFS_REGPROT = 8'h0c;
  localparam logic [7:0] OFS_CLKSEL  = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_SLOWREG = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned PCC_DIV_LSB   = 0;
  localparam int unsigned PCC_SUB_BIT   = 3;
  localparam int unsigned PCC_MCK_BIT   = 6;
  localparam int unsigned PLL_ON_BIT    = 0;
  localparam int unsigned TMM_SEL_LSB   = 0;
  localparam int unsigned WATCH_SEL_BIT = 3;
  localparam int unsigned WDT_SEL_LSB   = 4;
  localparam int unsigned STAT_SUB      = 0;
  localparam int unsigned STAT_LV       = 1;
  localparam int unsigned STAT_PROT_EN  = 2;
  localparam int unsigned STAT_DMA      = 3;
  localparam int unsigned STAT_DAC      = 4;
  localparam int unsigned STAT_CRC      = 5;

  // ----------------------------------------------------------------
  // Data values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PROT_ENABLE  = 8'hc9;
  localparam logic [7:0] PROT_LOCK    = 8'h00;
  localparam logic [7:0] LVL_NORMAL   = 8'h00;
  localparam logic [7:0] LVL_LOW      = 8'h02;
  localparam logic [7:0] PCC_RST      = 8'h03;
  localparam logic [7:0] PLL_RST      = 8'h00;
  localparam logic [7:0] LVL_RST      = 8'h00;
  localparam logic [7:0] PROT_RST     = 8'h00;
  localparam logic [7:0] CLKSEL_RST   = 8'h00;
  localparam logic [7:0] SLOWREG_RST  = 8'h00;

  // Count clock selector codes
  localparam logic [2:0] TMM_SEL_FR_DIV8 = 3'h2;
  localparam logic [2:0] TMM_SEL_SUB     = 3'h5;
  localparam logic [1:0] WDT_SEL_FR_DIV8 = 2'h1;
  localparam logic [1:0] WDT_SEL_SUB     = 2'h2;
  localparam logic       WATCH_SEL_SUB   = 1'b1;

  // Extra bus wait cycles of the wait-configured register
  localparam logic [3:0] SLOW_WAIT_CYCLES = 4'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MODE_NORMAL, MODE_SUB, MODE_LVSUB} lvsc_mode_t;

  typedef struct packed {
    logic cpu;
    logic intc;
    logic low_voltage_detector;
    logic key_int;
    logic sub_osc;
    logic int_osc;
    logic timer_p;
    logic timer_q;
    logic twowire;
    logic extra_uart;
    logic adc;
    logic rto_run;
    logic timer_m;
    logic watch;
    logic wdt2;
  } lvsc_run_t;

  typedef struct packed {
    logic dma;
    logic dac;
    logic crc;
  } lvsc_busy_t;

  typedef struct packed {
    logic       pll_on;
    logic       main_osc_stop;
    logic       subclk_sel;
    logic [2:0] sysclk_div;
    logic       reg_low;
  } lvsc_clk_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic tmm_clk_ok(input logic [7:0] clksel);
    logic [2:0] s;
    s = clksel[TMM_SEL_LSB +: 3];
    return (s == TMM_SEL_FR_DIV8) || (s == TMM_SEL_SUB);
  endfunction

  function automatic logic wdt_clk_ok(input logic [7:0] clksel);
    logic [1:0] s;
    s = clksel[WDT_SEL_LSB +: 2];
    return (s == WDT_SEL_FR_DIV8) || (s == WDT_SEL_SUB);
  endfunction

endpackage

// ==== hw/lvsc_avmm_slave.sv ====
// Avalon-MM slave handshake for the mode controller registers.
// Assumes the master holds its request until it sees waitrequest low.
`timescale 1ns/1ps
`default_nettype none
module lvsc_avmm_slave
  import lvsc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic read_i,
  input  wire logic write_i,
  input  wire logic slow_i,
  input  wire logic hang_i,
  output logic      waitrequest_o,
  output logic      capture_o,
  output logic      wr_stb_o
);

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ACK, ST_HUNG} lvsc_bus_st_t;

  lvsc_bus_st_t state_reg;
  lvsc_bus_st_t state_next;
  logic [3:0]   cnt_reg;
  logic         wait_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (read_i || write_i) begin
          if (hang_i)
            state_next = ST_HUNG;
          else if (slow_i)
            state_next = ST_WAIT;
          else
            state_next = ST_ACK;
        end
      end
      ST_WAIT: begin
        if (cnt_reg == 4'h1)
          state_next = ST_ACK;
      end
      ST_ACK:  state_next = ST_IDLE;
      // Only a reset frees a stalled wait-state access
      ST_HUNG: state_next = ST_HUNG;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      cnt_reg <= 4'h0;
    else if (state_reg == ST_IDLE)
      cnt_reg <= SLOW_WAIT_CYCLES;
    else if (state_reg == ST_WAIT)
      cnt_reg <= cnt_reg - 4'h1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      wait_reg <= 1'b1;
    else
      wait_reg <= (state_next != ST_ACK);
  end

  assign waitrequest_o = wait_reg;
  assign capture_o     = (state_next == ST_ACK) && (state_reg != ST_ACK);
  // Write lands on the edge at which the master sees waitrequest low
  assign wr_stb_o      = (state_reg == ST_ACK) && write_i;

endmodule
`default_nettype wire

// ==== hw/lvsc_gate.sv ====
// Run/stop decisions for on-chip functions per power mode.
// Purely combinational; the top registers the result.
`timescale 1ns/1ps
`default_nettype none
module lvsc_gate
  import lvsc_pkg::*;
(
  input  wire lvsc_mode_t mode_i,
  input  wire logic [7:0] clksel_i,
  output lvsc_run_t       run_o
);

  logic lv;

  assign lv = (mode_i == MODE_LVSUB);

  always_comb begin
    // Always alive, whatever the regulator level
    run_o.cpu        = 1'b1;
    run_o.intc       = 1'b1;
    run_o.low_voltage_detector        = 1'b1;
    run_o.key_int    = 1'b1;
    run_o.sub_osc    = 1'b1;
    run_o.int_osc    = 1'b1;
    run_o.timer_p    = !lv;
    run_o.timer_q    = !lv;
    run_o.twowire    = !lv;
    run_o.extra_uart = !lv;
    run_o.adc        = !lv;
    // Low means outputs freeze at their last level
    run_o.rto_run    = !lv;
    run_o.timer_m    = !lv || tmm_clk_ok(clksel_i);
    run_o.watch      = !lv || (clksel_i[WATCH_SEL_BIT] == WATCH_SEL_SUB);
    run_o.wdt2       = !lv || wdt_clk_ok(clksel_i);
  end

endmodule
`default_nettype wire

// ==== sim/lvsc_top_assertions.sv ====
// Concurrent checks on the ports of the low-voltage subclock controller.
// Assumes binding to lvsc_top and a master that writes bits 7:0 only.
`timescale 1ns/1ps
`default_nettype none
module lvsc_top_assertions
  import lvsc_pkg::*;
(
  input wire logic        SYS_CLK_I,
  input wire logic        RESET_I,
  input wire logic [7:0]  AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0]  AVS_BYTEENABLE_I,
  input wire logic        AVS_WAITREQUEST_O,
  input wire lvsc_clk_t   CLK_CTRL_O,
  input wire lvsc_mode_t  MODE_O,
  input wire lvsc_run_t   RUN_O
);
  // ----------------------------------------------------------------
  // Shadow of accepted writes
  // ----------------------------------------------------------------
  logic       acc_w;
  logic       wr_lvl;
  logic       wr_pcc;
  logic       unl_reg;
  logic [7:0] lvl_reg;
  logic [7:0] cs_reg;
  logic [7:0] cs_d_reg;
  logic [7:0] wd;
  assign wd     = AVS_WRITEDATA_I[7:0];
  assign acc_w  = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
  assign wr_lvl = acc_w && AVS_ADDRESS_I == OFS_REGLVL;
  assign wr_pcc = acc_w && AVS_ADDRESS_I == OFS_PCC;
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) unl_reg <= 1'b0;
    else if (acc_w && AVS_ADDRESS_I == OFS_REGPROT)
      unl_reg <= wd == PROT_ENABLE;
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) lvl_reg <= 8'h00;
    else if (wr_lvl && unl_reg) lvl_reg <= wd;
  end
  // Delayed copy lines up with the registered run enables
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) cs_reg <= 8'h00;
    else if (acc_w && AVS_ADDRESS_I == OFS_CLKSEL) cs_reg <= wd;
    cs_d_reg <= RESET_I ? 8'h00 : cs_reg;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  property p_lv_stop;
    MODE_O == MODE_LVSUB |-> !(RUN_O.timer_p || RUN_O.timer_q ||
      RUN_O.twowire || RUN_O.extra_uart || RUN_O.adc || RUN_O.rto_run);
  endproperty
  a_lv_stop: assert property (p_lv_stop) else $error("unit runs");
  property p_keep_run;
    RUN_O.cpu && RUN_O.intc && RUN_O.low_voltage_detector && RUN_O.key_int &&
      RUN_O.sub_osc && RUN_O.int_osc;
  endproperty
  a_keep_run: assert property (p_keep_run) else $error("core stop");
  property p_tmm;
    MODE_O == MODE_LVSUB |-> RUN_O.timer_m == (cs_d_reg[2:0] ==
      TMM_SEL_FR_DIV8 || cs_d_reg[2:0] == TMM_SEL_SUB);
  endproperty
  a_tmm: assert property (p_tmm) else $error("timer m gating wrong");
  property p_slow_timers;
    MODE_O == MODE_LVSUB |-> RUN_O.watch == cs_d_reg[WATCH_SEL_BIT] &&
      RUN_O.wdt2 == (cs_d_reg[5:4] == WDT_SEL_FR_DIV8 ||
      cs_d_reg[5:4] == WDT_SEL_SUB);
  endproperty
  a_slow_timers: assert property (p_slow_timers)
    else $error("watch gating");
  property p_lv_enter;
    wr_lvl && unl_reg && wd == LVL_LOW |-> ##2 MODE_O == MODE_LVSUB;
  endproperty
  a_lv_enter: assert property (p_lv_enter) else $error("no low mode");
  property p_locked;
    wr_lvl && !unl_reg |-> ##2 MODE_O == $past(MODE_O, 2);
  endproperty
  a_locked: assert property (p_locked) else $error("locked write acted");
  property p_pcc_hold;
    wr_pcc && !wd[PCC_SUB_BIT] && lvl_reg != LVL_NORMAL
      |-> ##2 CLK_CTRL_O.subclk_sel;
  endproperty
  a_pcc_hold: assert property (p_pcc_hold) else $error("deselect taken");
  property p_deselect;
    wr_pcc && !wd[PCC_SUB_BIT] && lvl_reg == LVL_NORMAL
      |-> ##2 MODE_O == MODE_NORMAL;
  endproperty
  a_deselect: assert property (p_deselect) else $error("no normal mode");
  property p_hang;
    (AVS_READ_I || AVS_WRITE_I) && AVS_ADDRESS_I == OFS_SLOWREG &&
      CLK_CTRL_O.subclk_sel && CLK_CTRL_O.main_osc_stop |-> AVS_WAITREQUEST_O;
  endproperty
  a_hang: assert property (p_hang) else $error("wait access answered");
  property p_rst_out;
    $fell(RESET_I) |-> MODE_O == MODE_NORMAL && RUN_O == '1
      ##1 MODE_O == MODE_NORMAL;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset state");
endmodule
bind lvsc_top lvsc_top_assertions u_chk (
  .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .CLK_CTRL_O(CLK_CTRL_O),
  .MODE_O(MODE_O), .RUN_O(RUN_O));
`default_nettype wire

// ==== sim/lvsc_top_tb_top.sv ====
// Self-checking bench for the low-voltage subclock controller.
// Drives the Avalon-MM port directly; the checker is bound separately.
`timescale 1ns/1ps
`default_nettype none
module lvsc_top_tb_top
  import lvsc_pkg::*;
  ;
  logic        clk;
  logic        rst;
  logic [7:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  lvsc_busy_t  busy;
  logic [31:0] rdata;
  logic        waitreq;
  lvsc_clk_t   clk_ctrl;
  lvsc_mode_t  mode;
  lvsc_run_t   run;
  int          seed;
  int          err_count;
  int          compares;
  logic [7:0]  d;
  logic [7:0]  cs;

  lvsc_top dut (.SYS_CLK_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
    .AVS_BYTEENABLE_I(be), .BUSY_I(busy), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(waitreq), .CLK_CTRL_O(clk_ctrl), .MODE_O(mode),
    .RUN_O(run));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk_rd(input string n, input logic [31:0] e,
                        input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_port(input string n, input lvsc_mode_t em,
                          input lvsc_run_t er);
    compares++;
    if ({mode, run} !== {em, er}) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, {em, er}, {mode, run});
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v,
                     output logic [31:0] q);
    addr <= a;
    wdata <= {24'h000000, v};
    wr <= w;
    rd <= !w;
    // No assumed latency; only the watchdog ends a stalled wait
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] v);
    logic [31:0] q;
    acc(1'b1, a, v, q);
  endtask
  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [7:0] e);
    logic [31:0] q;
    acc(1'b0, a, 8'h00, q);
    chk_rd(n, {24'h000000, e}, q);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
  endtask
  // Protected level update: unlock, write, relock
  // No interrupt source is raised by the bench during the sequence
  task automatic set_lvl(input logic [7:0] v);
    wr8(OFS_REGPROT, PROT_ENABLE);
    wr8(OFS_REGLVL, v);
    wr8(OFS_REGPROT, PROT_LOCK);
    settle();
  endtask
  function automatic lvsc_run_t exp_run(input lvsc_mode_t m,
                                        input logic [7:0] c);
    lvsc_run_t r;
    r = '1;
    if (m == MODE_LVSUB) begin
      {r.timer_p, r.timer_q, r.twowire, r.extra_uart, r.adc} = 5'h00;
      r.rto_run = 1'b0;
      r.timer_m = c[2:0] == TMM_SEL_FR_DIV8 || c[2:0] == TMM_SEL_SUB;
      r.watch = c[WATCH_SEL_BIT] == WATCH_SEL_SUB;
      r.wdt2 = c[5:4] == WDT_SEL_FR_DIV8 || c[5:4] == WDT_SEL_SUB;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Clock, watchdog, sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end
  initial begin
    {rst, addr, rd, wr} = {1'b1, 8'h00, 2'h0};
    {wdata, be, busy} = {32'h0, 4'h1, 3'h0};
    {seed, err_count, compares} = {32'h532d, 32'h0, 32'h0};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc("level", OFS_REGLVL, LVL_RST);
    rdc("protect", OFS_REGPROT, PROT_RST);
    chk_port("reset", MODE_NORMAL, '1);
    for (int i = 0; i < 4; i++) begin
      busy <= lvsc_busy_t'(3'($random(seed)));
      d = 8'($random(seed));
      wr8(OFS_SLOWREG, d);
      rdc("slow", OFS_SLOWREG, d);
      rdc("status", OFS_STATUS,
          {2'h0, busy.crc, busy.dac, busy.dma, 3'h0});
    end
    be <= 4'h0;
    wr8(OFS_SLOWREG, ~d);
    be <= 4'h1;
    rdc("no lanes", OFS_SLOWREG, d);
    rdc("unmapped", 8'h20, 8'h00);
    wr8(OFS_PLL, 8'h00);
    wr8(OFS_PCC, 8'h4b);
    wr8(OFS_REGLVL, LVL_LOW);
    settle();
    rdc("locked level", OFS_REGLVL, LVL_NORMAL);
    chk_port("locked", MODE_SUB, '1);
    set_lvl(LVL_LOW);
    chk_port("low", MODE_LVSUB, exp_run(MODE_LVSUB, 8'h00));
    // Bench drives no external serial or baud clock while low
    chk_port("ext clocks", MODE_LVSUB, exp_run(MODE_LVSUB, 8'h00));
    rdc("relock", OFS_REGPROT, PROT_LOCK);
    for (int i = 0; i < 16; i++) begin
      cs = i < 8 ? {2'h0, i[1:0], i[0], i[2:0]} : 8'($random(seed));
      wr8(OFS_CLKSEL, cs);
      settle();
      chk_port("gating", MODE_LVSUB, exp_run(MODE_LVSUB, cs));
    end
    wr8(OFS_PCC, 8'h43);
    settle();
    rdc("select kept", OFS_PCC, 8'h4b);
    set_lvl(LVL_NORMAL);
    // Recovery wait shortened; 800 us would exceed the run budget
    settle();
    chk_port("restored", MODE_SUB, '1);
    wr8(OFS_PCC, 8'h0b);
    wr8(OFS_PCC, 8'h03);
    settle();
    chk_port("normal", MODE_NORMAL, '1);
    wr8(OFS_PCC, 8'h4b);
    set_lvl(LVL_LOW);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk_port("reset exit", MODE_NORMAL, '1);
    rdc("level reset", OFS_REGLVL, LVL_RST);
    wr8(OFS_PCC, 8'h4b);
    settle();
    addr <= OFS_SLOWREG;
    rd <= 1'b1;
    repeat (30) begin
      @(posedge clk);
      chk_rd("hung wait", 32'h1, {31'h0, waitreq});
    end
    rst <= 1'b1;
    rd <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc("freed", OFS_PCC, PCC_RST);
    conclude();
  end
endmodule
`default_nettype wire
